// *** logic/ccs_device.sv ***
// Device end: reset, access gate, clock select straps, reference clock
// routing, general-purpose pin, transmit high-z, interrupt, chip select.
// Assumes host drives bus pins synchronously; straps are static.
//
// Contract
// - Strap two high selects 2.048 MHz base
// - Lower straps give multiplier one to four
// - Oscillator output is inverted oscillator input
// - Generated clock at 1.544 or 2.048 MHz
// - Reference A link chosen by select bit 0
// - Reference B link chosen by select bit 3
// - Low reset over 100 ns resets all
// - Registers accessible 2 ms after reset
// - Reset only with running oscillator clock
// - Gp pin direction from control bit 0
// - Input gp pin level read in bit 2
// - Output gp pin driven from bit 2
// - Transmit high-z floats the one tip-ring line output
// - Interrupt low while unmasked indication set
// - Bus ignored while chip select high
// - Chip select high clears test modes
// - Fresh chip select fall per access
// - Oscillator frequency interpreted from three straps
`timescale 1ns/1ps
module ccs_device #(
  parameter int unsigned ACCESS_DELAY = ccs_pkg::ACCESS_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host pins
  ccs_if.device bus,
  // Clock pins
  input wire logic osc_in,
  output logic osc_out,
  input wire logic [2:0] clk_sel,
  output logic generated_clock_out,
  output logic [2:0] ref_multiplier,
  output logic ref_base_e1,
  // Recovered clocks
  input wire logic [1:0] recovered_clock_in,
  output logic recovered_clock_out_a,
  output logic recovered_clock_out_b,
  // General purpose pin
  input wire logic gp_pin_in,
  output logic gp_pin_out,
  output logic gp_pin_oe,
  // Transmit high-z
  input wire logic transmit_high_z,
  output logic line_tx_tip_ring_oe,
  // Interrupts from link logic
  input wire logic [7:0] irq_indication,
  input wire logic [7:0] irq_enable,
  // Status
  output logic access_ready,
  output logic test_mode
);
  typedef struct packed {
    logic [1:0] rn_sync;
    logic [1:0] cs_sync;
    logic [1:0] wr_sync;
    logic [1:0] rd_sync;
    logic [1:0] gp_sync;
    logic [1:0] thz_sync;
    logic [1:0] rc_a_sync;
    logic [1:0] rc_b_sync;
    logic [1:0] osc_sync;
    logic [2:0] sel_a_sync;
    logic [2:0] sel_b_sync;
    logic [2:0] sel_c_sync;
    logic armed;
    logic [3:0] low_cnt;
    logic [31:0] wait_cnt;
    logic ready;
    logic test;
    logic gp_dir;
    logic gp_level;
    logic ref_a_sel;
    logic ref_b_sel;
    logic [4:0] div_cnt;
    logic gen_clk;
    logic [7:0] rdata;
    logic rvalid;
    logic osc_out;
    logic ref_a;
    logic ref_b;
    logic gp_out;
    logic gp_oe;
    logic tx_oe;
    logic int_oe;
    logic [2:0] mult;
    logic base_e1;
  } ccs_dev_state_t;

  ccs_dev_state_t s;
  ccs_dev_state_t next_s;
  logic any_irq;
  logic hw_reset;

  always_comb begin
    next_s = s;
    any_irq = |(irq_indication & irq_enable);
    hw_reset = 1'b0;
    next_s.rn_sync = {s.rn_sync[0], bus.reset_n};
    next_s.cs_sync = {s.cs_sync[0], bus.cs_n};
    next_s.wr_sync = {s.wr_sync[0], bus.wr_n};
    next_s.rd_sync = {s.rd_sync[0], bus.rd_n};
    next_s.gp_sync = {s.gp_sync[0], gp_pin_in};
    next_s.thz_sync = {s.thz_sync[0], transmit_high_z};
    next_s.rc_a_sync = {s.rc_a_sync[0], recovered_clock_in[0]};
    next_s.rc_b_sync = {s.rc_b_sync[0], recovered_clock_in[1]};
    next_s.osc_sync = {s.osc_sync[0], osc_in};
    next_s.sel_a_sync = clk_sel;
    next_s.sel_b_sync = s.sel_a_sync;
    next_s.sel_c_sync = s.sel_b_sync;
    next_s.rvalid = 1'b0;
    // Reset pin low long enough
    if (!s.rn_sync[1]) begin
      if (s.low_cnt != 4'(ccs_pkg::RESET_MIN_CYC)) begin
        next_s.low_cnt = s.low_cnt + 4'h1;
      end
    end else begin
      next_s.low_cnt = 4'h0;
    end
    if (!s.rn_sync[1] && s.low_cnt == 4'(ccs_pkg::RESET_MIN_CYC)) begin
      hw_reset = 1'b1;
    end
    // Access delay
    if (!s.ready) begin
      if (s.wait_cnt == 32'(ACCESS_DELAY - 1)) begin
        next_s.ready = 1'b1;
      end else begin
        next_s.wait_cnt = s.wait_cnt + 32'h1;
      end
    end
    // Chip select high clears test modes
    if (s.cs_sync[1]) begin
      next_s.test = 1'b0;
      next_s.armed = 1'b1;
    end
    // One access per chip select fall
    if (s.ready && !s.cs_sync[1] && s.armed) begin
      if (!s.wr_sync[1]) begin
        next_s.armed = 1'b0;
        if (bus.addr == ccs_pkg::REG_GPIO_CONTROL) begin
          next_s.gp_dir = bus.wdata[ccs_pkg::BIT_GP_DIRECTION];
          next_s.gp_level = bus.wdata[ccs_pkg::BIT_GP_LEVEL];
        end else if (bus.addr == ccs_pkg::REG_REF_OUTPUT_SELECT) begin
          next_s.ref_a_sel = bus.wdata[ccs_pkg::BIT_REF_A_SELECT];
          next_s.ref_b_sel = bus.wdata[ccs_pkg::BIT_REF_B_SELECT];
        end
      end else if (!s.rd_sync[1]) begin
        next_s.armed = 1'b0;
        next_s.rvalid = 1'b1;
        next_s.rdata = 8'h00;
        if (bus.addr == ccs_pkg::REG_GPIO_CONTROL) begin
          next_s.rdata[ccs_pkg::BIT_GP_DIRECTION] = s.gp_dir;
          next_s.rdata[ccs_pkg::BIT_GP_LEVEL] = s.gp_dir ? s.gp_level : s.gp_sync[1];
        end else if (bus.addr == ccs_pkg::REG_REF_OUTPUT_SELECT) begin
          next_s.rdata[ccs_pkg::BIT_REF_A_SELECT] = s.ref_a_sel;
          next_s.rdata[ccs_pkg::BIT_REF_B_SELECT] = s.ref_b_sel;
        end
      end
    end
    // Straps decode
    next_s.base_e1 = s.sel_c_sync[2];
    next_s.mult = 3'({1'b0, s.sel_c_sync[1:0]}) + 3'h1;
    // Generated clock divider
    if (s.div_cnt == 5'h0) begin
      next_s.gen_clk = ~s.gen_clk;
      next_s.div_cnt = (s.base_e1 ? ccs_pkg::HALF_E1 : ccs_pkg::HALF_T1) - 5'h1;
    end else begin
      next_s.div_cnt = s.div_cnt - 5'h1;
    end
    next_s.osc_out = ~s.osc_sync[1];
    next_s.ref_a = s.ref_a_sel ? s.rc_b_sync[1] : s.rc_a_sync[1];
    next_s.ref_b = s.ref_b_sel ? s.rc_b_sync[1] : s.rc_a_sync[1];
    next_s.gp_oe = s.gp_dir;
    next_s.gp_out = s.gp_level;
    next_s.tx_oe = ~s.thz_sync[1];
    next_s.int_oe = any_irq;
    if (hw_reset) begin
      next_s.ready = 1'b0;
      next_s.wait_cnt = 32'h0;
      next_s.gp_dir = 1'b0;
      next_s.gp_level = 1'b0;
      next_s.ref_a_sel = 1'b0;
      next_s.ref_b_sel = 1'b0;
      next_s.test = 1'b1;
      next_s.armed = 1'b0;
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.rn_sync <= 2'h3;
      s.cs_sync <= 2'h3;
      s.wr_sync <= 2'h3;
      s.rd_sync <= 2'h3;
      s.test <= 1'b1;
      s.mult <= 3'h1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.rdata = s.rdata;
  assign bus.rdata_valid = s.rvalid;
  assign bus.int_n_oe = s.int_oe;
  assign osc_out = s.osc_out;
  assign generated_clock_out = s.gen_clk;
  assign ref_multiplier = s.mult;
  assign ref_base_e1 = s.base_e1;
  assign recovered_clock_out_a = s.ref_a;
  assign recovered_clock_out_b = s.ref_b;
  assign gp_pin_out = s.gp_out;
  assign gp_pin_oe = s.gp_oe;
  assign line_tx_tip_ring_oe = s.tx_oe;
  assign access_ready = s.ready;
  assign test_mode = s.test;
endmodule : ccs_device

// *** logic/ccs_host.sv ***
// Host end: drives reset and one access per chip select cycle.
// Assumes software writes command registers on a plain strobe port.
`timescale 1ns/1ps
module ccs_host #(
  parameter int unsigned ACCESS_DELAY = ccs_pkg::ACCESS_DELAY_CYC,
  parameter int unsigned HOLD_CYC = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Software port
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Device pins
  ccs_if.host bus,
  input wire logic osc_running
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RESET = 4'h2, ST_WAIT = 4'h4, ST_ACCESS = 4'h8
  } ccs_host_st_t;

  typedef struct packed {
    ccs_host_st_t st;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic is_read;
    logic [31:0] cnt;
    logic reset_n;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic ready;
    logic busy;
    logic [15:0] sw_rdata;
    logic [1:0] int_sync;
  } ccs_host_state_t;

  ccs_host_state_t s;
  ccs_host_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.int_sync = {s.int_sync[0], bus.int_n_oe};
    next_s.sw_rdata = 16'h0000;
    if (sw_rd) begin
      unique case (sw_addr)
        ccs_pkg::HOST_REG_ADDR: next_s.sw_rdata = {7'h00, s.addr};
        ccs_pkg::HOST_REG_WDATA: next_s.sw_rdata = {8'h00, s.wdata};
        ccs_pkg::HOST_REG_STATUS: next_s.sw_rdata = {13'h0000, s.int_sync[1], s.busy, s.ready};
        ccs_pkg::HOST_REG_RDATA: next_s.sw_rdata = {8'h00, s.rdata};
        default: next_s.sw_rdata = 16'h0000;
      endcase
    end
    if (sw_wr && sw_addr == ccs_pkg::HOST_REG_ADDR) begin
      next_s.addr = sw_wdata[8:0];
    end
    if (sw_wr && sw_addr == ccs_pkg::HOST_REG_WDATA) begin
      next_s.wdata = sw_wdata[7:0];
    end
    unique case (s.st)
      ST_IDLE: begin
        if (sw_wr && sw_addr == ccs_pkg::HOST_REG_CMD) begin
          if (sw_wdata[ccs_pkg::CMD_BIT_RESET] && osc_running) begin
            next_s.st = ST_RESET;
            next_s.reset_n = 1'b0;
            next_s.ready = 1'b0;
            next_s.busy = 1'b1;
            next_s.cnt = 32'h0;
          end else if (s.ready && (sw_wdata[ccs_pkg::CMD_BIT_WRITE]
                       || sw_wdata[ccs_pkg::CMD_BIT_READ])) begin
            next_s.st = ST_ACCESS;
            next_s.is_read = sw_wdata[ccs_pkg::CMD_BIT_READ];
            next_s.cs_n = 1'b0;
            next_s.busy = 1'b1;
            next_s.cnt = 32'h0;
          end
        end
      end
      ST_RESET: begin
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt == 32'(ccs_pkg::RESET_MIN_CYC + 4)) begin
          next_s.reset_n = 1'b1;
          next_s.st = ST_WAIT;
          next_s.cnt = 32'h0;
        end
      end
      ST_WAIT: begin
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt == 32'(ACCESS_DELAY + 8)) begin
          next_s.ready = 1'b1;
          next_s.busy = 1'b0;
          next_s.st = ST_IDLE;
        end
      end
      ST_ACCESS: begin
        next_s.cnt = s.cnt + 32'h1;
        next_s.wr_n = s.is_read;
        next_s.rd_n = ~s.is_read;
        if (bus.rdata_valid) begin
          next_s.rdata = bus.rdata;
        end
        if (s.cnt == 32'(HOLD_CYC)) begin
          next_s.wr_n = 1'b1;
          next_s.rd_n = 1'b1;
          next_s.cs_n = 1'b1;
          next_s.busy = 1'b0;
          next_s.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      // Power-up waits out the access delay too
      s.st <= ST_WAIT;
      s.busy <= 1'b1;
      s.reset_n <= 1'b1;
      s.cs_n <= 1'b1;
      s.wr_n <= 1'b1;
      s.rd_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sw_rdata = s.sw_rdata;
  assign bus.reset_n = s.reset_n;
  assign bus.cs_n = s.cs_n;
  assign bus.addr = s.addr;
  assign bus.wdata = s.wdata;
  assign bus.wr_n = s.wr_n;
  assign bus.rd_n = s.rd_n;
endmodule : ccs_host

// *** logic/ccs_if.sv ***
// Interface: pins between the chip control device and its host.
// Assumes both ends run on one clock; open-drain pins resolved by bench.
`timescale 1ns/1ps
interface ccs_if;
  logic reset_n;
  logic cs_n;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic wr_n;
  logic rd_n;
  logic [7:0] rdata;
  logic rdata_valid;
  logic int_n_oe;
  modport device (
    input reset_n, cs_n, addr, wdata, wr_n, rd_n,
    output rdata, rdata_valid, int_n_oe
  );
  modport host (
    output reset_n, cs_n, addr, wdata, wr_n, rd_n,
    input rdata, rdata_valid, int_n_oe
  );
endinterface : ccs_if

// *** logic/ccs_pkg.sv ***
// Package: constants shared by the chip control device end and its host end.
// Assumes a single 50 MHz clock for both ends.
package ccs_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  // Reset and access timing
  localparam int unsigned RESET_MIN_NS = 100;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS * 50 + 999) / 1000;
  localparam int unsigned ACCESS_DELAY_US = 2000;
  localparam int unsigned ACCESS_DELAY_CYC = ACCESS_DELAY_US * (CLK_HZ / 1000000);
  // Register map
  localparam logic [8:0] REG_GPIO_CONTROL = 9'h006;
  localparam logic [8:0] REG_REF_OUTPUT_SELECT = 9'h007;
  localparam int unsigned BIT_GP_DIRECTION = 0;
  localparam int unsigned BIT_GP_LEVEL = 2;
  localparam int unsigned BIT_REF_A_SELECT = 0;
  localparam int unsigned BIT_REF_B_SELECT = 3;
  // Host command port registers
  localparam logic [3:0] HOST_REG_ADDR = 4'h0;
  localparam logic [3:0] HOST_REG_WDATA = 4'h1;
  localparam logic [3:0] HOST_REG_CMD = 4'h2;
  localparam logic [3:0] HOST_REG_STATUS = 4'h3;
  localparam logic [3:0] HOST_REG_RDATA = 4'h4;
  localparam int unsigned CMD_BIT_WRITE = 0;
  localparam int unsigned CMD_BIT_READ = 1;
  localparam int unsigned CMD_BIT_RESET = 2;
  // Generated clock divider half periods (approximate at 50 MHz)
  localparam logic [4:0] HALF_T1 = 5'h10;
  localparam logic [4:0] HALF_E1 = 5'h0C;
endpackage : ccs_pkg

// *** verification/ccs_properties.sv ***
// Checker: timing relations on the pins between host and device ends.
// Assumes instantiation beside the interface, one clock domain.
`timescale 1ns/1ps
module ccs_properties #(
  parameter int unsigned ACCESS_DELAY = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Interface signals
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic rdata_valid,
  input wire logic int_n_oe,
  // Device pins
  input wire logic osc_in,
  input wire logic osc_out,
  input wire logic [7:0] irq_indication,
  input wire logic [7:0] irq_enable,
  input wire logic access_ready,
  input wire logic test_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] wait_cnt;
  // Cycles since any reset while not yet ready
  always_ff @(posedge clk) begin
    if (rst || !reset_n) begin
      wait_cnt <= 8'h00;
    end else if (!access_ready && wait_cnt != 8'hFF) begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
  property p_int_set;
    (|(irq_indication & irq_enable)) [*3] |-> int_n_oe;
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt not driven");
  property p_int_clear;
    !(|(irq_indication & irq_enable)) [*3] |-> !int_n_oe;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not released");
  property p_valid_pulse;
    rdata_valid |=> !rdata_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("read pulse too long");
  property p_valid_gated;
    rdata_valid |-> !cs_n && !rd_n && access_ready;
  endproperty
  a_valid_gated: assert property (p_valid_gated) else $error("read outside access");
  property p_ready_delay;
    $rose(access_ready) |-> wait_cnt >= ACCESS_DELAY - 1 && wait_cnt <= ACCESS_DELAY + 8;
  endproperty
  a_ready_delay: assert property (p_ready_delay) else $error("access delay wrong");
  property p_pin_reset;
    !reset_n [*8] |-> ##[0:6] !access_ready;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");
  property p_test_clear;
    (cs_n && reset_n) [*6] |=> !test_mode;
  endproperty
  a_test_clear: assert property (p_test_clear) else $error("test mode kept");
  property p_osc_inv;
    (reset_n && $stable(osc_in)) [*6] |-> osc_out == !osc_in;
  endproperty
  a_osc_inv: assert property (p_osc_inv) else $error("oscillator out wrong");
  c_read: cover property (rdata_valid);
  c_int: cover property (int_n_oe);
  c_pin_reset: cover property (!reset_n ##1 reset_n);
endmodule : ccs_properties

// *** verification/ccs_tb_top.sv ***
// Bench: host and device ends joined, driven through the software port.
// Assumes a 50 MHz clock and a shortened access delay.
`timescale 1ns/1ps
module ccs_tb_top;
  localparam int unsigned DLY = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic osc_running = 1'b1;
  logic osc_in = 1'b0;
  logic [3:0] oc = 4'h0;
  logic [2:0] clk_sel = 3'h0;
  logic [1:0] rec = 2'h0;
  logic gp_pin_in = 1'b0;
  logic transmit_high_z = 1'b0;
  logic [7:0] irq_ind = 8'h00;
  logic [7:0] irq_en = 8'h00;
  logic [15:0] sw_rdata, d;
  logic [2:0] mult;
  logic osc_out, gen_clk, base_e1, ref_a, ref_b, gp_out, gp_oe, tx_oe, ready, test_mode;
  int fail_count = 0;
  int compares = 0;
  always #10 clk = ~clk;
  // Free-running oscillator, 16 cycles a period
  always @(posedge clk) begin
    oc <= oc + 4'h1;
    osc_in <= oc[3];
  end
  ccs_if bus_if ();
  ccs_device #(.ACCESS_DELAY(DLY)) ccs_device_i (.clk(clk), .rst(rst), .bus(bus_if),
    .osc_in(osc_in), .osc_out(osc_out), .clk_sel(clk_sel), .generated_clock_out(gen_clk),
    .ref_multiplier(mult), .ref_base_e1(base_e1), .recovered_clock_in(rec),
    .recovered_clock_out_a(ref_a), .recovered_clock_out_b(ref_b), .gp_pin_in(gp_pin_in),
    .gp_pin_out(gp_out), .gp_pin_oe(gp_oe), .transmit_high_z(transmit_high_z),
    .line_tx_tip_ring_oe(tx_oe), .irq_indication(irq_ind), .irq_enable(irq_en),
    .access_ready(ready), .test_mode(test_mode));
  ccs_host #(.ACCESS_DELAY(DLY)) ccs_host_i (.clk(clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus_if),
    .osc_running(osc_running));
  ccs_properties #(.ACCESS_DELAY(DLY)) ccs_properties_i (.clk(clk), .rst(rst),
    .reset_n(bus_if.reset_n), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
    .rdata_valid(bus_if.rdata_valid), .int_n_oe(bus_if.int_n_oe), .osc_in(osc_in),
    .osc_out(osc_out), .irq_indication(irq_ind), .irq_enable(irq_en),
    .access_ready(ready), .test_mode(test_mode));
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask : settle
  task automatic sw_w(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_w
  task automatic sw_r(input logic [3:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : sw_r
  // Poll a status bit under a bound
  task automatic wait_st(input int b, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      sw_r(ccs_pkg::HOST_REG_STATUS);
      if (d[b] === v) return;
    end
    fail_count++;
    $display("mismatch at %0t: status wait ran out", $time);
    test_done();
  endtask : wait_st
  task automatic dev_go(input logic [8:0] a, input logic [15:0] cmd);
    sw_w(ccs_pkg::HOST_REG_ADDR, {7'h00, a});
    sw_w(ccs_pkg::HOST_REG_CMD, cmd);
    wait_st(1, 1'b0, 50);
  endtask : dev_go
  task automatic dev_w(input logic [8:0] a, input logic [7:0] v);
    sw_w(ccs_pkg::HOST_REG_WDATA, {8'h00, v});
    dev_go(a, 16'h0001);
  endtask : dev_w
  task automatic dev_r(input logic [8:0] a);
    dev_go(a, 16'h0002);
    sw_r(ccs_pkg::HOST_REG_RDATA);
  endtask : dev_r
  task automatic t_straps;
    int t0, t1;
    logic g;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      clk_sel <= s[2:0];
      repeat (80) @(posedge clk);
      #1;
      check(mult, s[1:0] + 3'h1);
      check(base_e1, s[2]);
      g = gen_clk;
      t0 = 0;
      t1 = 0;
      for (int i = 1; i < 80; i++) begin
        @(posedge clk);
        #1;
        if (gen_clk !== g) begin
          g = gen_clk;
          t0 = t1;
          t1 = i;
        end
      end
      check(t1 - t0, s[2] ? ccs_pkg::HALF_E1 : ccs_pkg::HALF_T1);
    end
  endtask : t_straps
  task automatic t_refsel;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = {4'h0, k[1], 2'h0, k[0]};
      dev_w(ccs_pkg::REG_REF_OUTPUT_SELECT, v);
      dev_r(ccs_pkg::REG_REF_OUTPUT_SELECT);
      check(d[7:0], v);
      for (int c = 1; c < 3; c++) begin
        @(posedge clk);
        rec <= c[1:0];
        settle();
        check({ref_a, ref_b}, {c[k[0]], c[k[1]]});
      end
    end
  endtask : t_refsel
  task automatic t_gpio;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      gp_pin_in <= i[0];
      settle();
      dev_r(ccs_pkg::REG_GPIO_CONTROL);
      check({d[2], d[0], gp_oe}, {i[0], 2'h0});
    end
    dev_w(ccs_pkg::REG_GPIO_CONTROL, 8'h05);
    check({gp_oe, gp_out}, 2'h3);
    dev_w(ccs_pkg::REG_GPIO_CONTROL, 8'h01);
    check({gp_oe, gp_out}, 2'h2);
    dev_r(ccs_pkg::REG_GPIO_CONTROL);
    check(d[7:0], 8'h01);
    dev_w(ccs_pkg::REG_GPIO_CONTROL, 8'h00);
    check(gp_oe, 1'b0);
    dev_r(9'h010);
    check(d[7:0], 8'h00);
  endtask : t_gpio
  task automatic t_pins;
    logic [7:0] ind_t [4] = '{8'h80, 8'h80, 8'h81, 8'h00};
    logic [7:0] en_t [4] = '{8'h00, 8'h80, 8'h7F, 8'hFF};
    logic [3:0] int_t = 4'b0110;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      transmit_high_z <= i[0];
      irq_ind <= ind_t[i];
      irq_en <= en_t[i];
      settle();
      check(tx_oe, !i[0]);
      check(bus_if.int_n_oe, int_t[i]);
      sw_r(ccs_pkg::HOST_REG_STATUS);
      check(d[2], int_t[i]);
    end
  endtask : t_pins
  task automatic t_reset;
    dev_w(ccs_pkg::REG_REF_OUTPUT_SELECT, 8'h09);
    @(posedge clk);
    osc_running <= 1'b0;
    sw_w(ccs_pkg::HOST_REG_CMD, 16'h0004);
    repeat (20) @(posedge clk);
    #1;
    check(ready, 1'b1);
    @(posedge clk);
    osc_running <= 1'b1;
    sw_w(ccs_pkg::HOST_REG_CMD, 16'h0004);
    repeat (15) @(posedge clk);
    #1;
    check(ready, 1'b0);
    wait_st(0, 1'b1, 60);
    dev_r(ccs_pkg::REG_REF_OUTPUT_SELECT);
    check(d[7:0], 8'h00);
  endtask : t_reset
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_st(0, 1'b1, 40);
    check({ready, test_mode, gp_oe}, 3'h4);
    t_straps();
    t_refsel();
    t_gpio();
    t_pins();
    t_reset();
    test_done();
  end
endmodule : ccs_tb_top
